//--- src/udf_pkg.sv
package udf_pkg;
    // frame geometry
    localparam int NUM_DIGI = 8;
    localparam int NUM_ALIAS = 4;
    localparam int CALL_CHARS = 6;
    localparam int NAME_MAX = 5;

    // register word indices (Avalon word address)
    localparam logic [5:0] W_OWN = 6'h00;
    localparam logic [5:0] W_GATE = 6'h02;
    localparam logic [5:0] W_ALIAS = 6'h04;
    localparam logic [5:0] W_FLOOD = 6'h0C;
    localparam logic [5:0] W_TRACE = 6'h0E;
    localparam logic [5:0] W_CFG = 6'h10;
    localparam logic [5:0] W_UDEST = 6'h11;
    localparam logic [5:0] W_UDIGI = 6'h13;
    localparam logic [5:0] W_UCTL = 6'h23;
    localparam logic [5:0] W_STAT = 6'h24;
    localparam int NUM_RW = 36;

    // config word fields
    localparam int CFG_ALIAS_EN = 0;
    localparam int CFG_FLOOD_EN = 1;
    localparam int CFG_FLOOD_ID = 2;
    localparam int CFG_TRACE_EN = 3;
    localparam int CFG_GATE0 = 4;
    localparam int CFG_UI_WAIT = 6;
    localparam int CFG_DUP_LSB = 8;

    // high word of a call: chars 4..5 in [15:0]
    localparam int HI_SSID_LSB = 16;
    localparam int HI_LEN_LSB = 20;
    localparam int HI_EN = 23;
    localparam int HI_HOLD_LSB = 24;

    // unconnected path control word
    localparam int UCTL_CNT_LSB = 0;
    localparam int UCTL_NONE = 4;
    localparam int UCTL_PORT = 5;

    // reset values
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] NAME_HI_RST = 32'h1E00_0000;
    localparam logic [31:0] UDEST_LO_RST = 32'h2020_5143;
    localparam logic [31:0] UDEST_HI_RST = 32'h0000_2020;

    // characters
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_SEVEN = 8'h37;

    typedef enum logic [1:0] {
        UDF_KIND_DATA = 2'h0,
        UDF_KIND_BEACON = 2'h1,
        UDF_KIND_ID = 2'h2
    } udf_kind_e;

    typedef enum logic [1:0] {
        UDF_IDLE = 2'h0,
        UDF_BODY = 2'h1,
        UDF_DECIDE = 2'h3,
        UDF_OUT = 2'h2
    } udf_state_e;

    typedef struct packed {
        logic [47:0] call;
        logic [3:0] ssid;
        logic rep;
    } udf_addr_s;

    typedef struct packed {
        udf_addr_s dest;
        udf_addr_s src;
        udf_addr_s [NUM_DIGI-1:0] digi;
        logic [3:0] numDigi;
        logic port;
        logic isUi;
        logic hasInfo;
    } udf_hdr_s;

    typedef struct packed {
        udf_hdr_s hdr;
        logic outPort;
        logic chanWait;
    } udf_relay_s;
endpackage

//--- src/udf_filter.sv
`timescale 1ns/1ps
// Operation
// - relay UI on any of four aliases unless own call in source or repeated fields
// - alias relay writes own call into matched field and sets repeated bit
// - alias, flood and trace relay checksum over source, destination, info; kept 0-255 seconds
// - qualifying frame with a retained checksum is dropped
// - checksum store never exceeds sixty-four entries
// - wait option off: special relays go when channel clear, no extra wait
// - wait option on: special relays use normal slot-time and persistence
// - flood matches name up to five chars, digit 1-7, identifier 1-7
// - flood decrements identifier and leaves repeated bit clear
// - flood identify option adds own call field with repeated bit set
// - own call never inserted when eight relay fields already present
// - reset: flood off, hold thirty seconds, identify off
// - trace inserts own call before match, decrements identifier, bit clear
// - trace suppresses duplicates for its hold; reset off, hold thirty
// - gateway-call frame on gated port relays out the other port
// - gateway-call frame on ungated port is discarded
// - unconnected path: one destination, up to eight relays in order
// - local unconnected frames go as UI, no ack, no retry
// - path set to none sends only beacon and identification frames
module udf_filter #(
    parameter int STORE_DEPTH = 64
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic secTick,
    input wire logic rxHdrValid,
    input wire udf_pkg::udf_hdr_s rxHdr,
    output logic rxHdrReady,
    input wire logic rxDataValid,
    input wire logic [7:0] rxData,
    input wire logic rxLast,
    output logic rxDataReady,
    output logic relayValid,
    output udf_pkg::udf_relay_s relay,
    input wire logic relayReady,
    input wire logic localReq,
    input wire udf_pkg::udf_kind_e localKind,
    output logic localValid,
    output udf_pkg::udf_hdr_s localHdr,
    input wire logic localReady,
    output logic localRefused
);
    localparam int PW = $clog2(STORE_DEPTH);

    // store pointer wraps naturally, so depth must be a power of two
    if (STORE_DEPTH < 2 || STORE_DEPTH > 64 || (1 << PW) != STORE_DEPTH) begin : g_chk
        $error("STORE_DEPTH must be a power of two from 2 to 64");
    end

    logic [31:0] regs [udf_pkg::NUM_RW];
    udf_pkg::udf_state_e state, next_state;
    udf_pkg::udf_hdr_s frm;
    logic [15:0] sum;
    logic [15:0] stSum [STORE_DEPTH];
    logic [7:0] stLeft [STORE_DEPTH];
    logic [PW-1:0] wrPtr;
    logic [15:0] relayCnt, dropCnt;

    // fold one byte into the running checksum
    function automatic logic [15:0] csStep(input logic [15:0] s, input logic [7:0] b);
        csStep = {s[14:0], s[15]} ^ {8'h00, b};
    endfunction

    function automatic logic [15:0] csAddr(input logic [15:0] s, input udf_pkg::udf_addr_s a);
        logic [15:0] r;
        r = s;
        for (int k = 0; k < udf_pkg::CALL_CHARS; k++) begin
            r = csStep(r, a.call[8*k +: 8]);
        end
        csAddr = csStep(r, {4'h0, a.ssid});
    endfunction

    function automatic udf_pkg::udf_addr_s regAddr(input int w);
        regAddr.call = {regs[w+1][15:0], regs[w]};
        regAddr.ssid = regs[w+1][udf_pkg::HI_SSID_LSB +: 4];
        regAddr.rep = 1'b0;
    endfunction

    function automatic logic sameStn(input udf_pkg::udf_addr_s a, input udf_pkg::udf_addr_s b);
        sameStn = (a.call == b.call) && (a.ssid == b.ssid);
    endfunction

    // name + digit 1..7, blanks after, identifier 1..7
    function automatic logic nameMatch(input udf_pkg::udf_addr_s a, input int w);
        logic [2:0] len;
        logic ok;
        logic [7:0] c, n;
        len = regs[w+1][udf_pkg::HI_LEN_LSB +: 3];
        ok = (len != 3'h0) && (len <= 3'(udf_pkg::NAME_MAX));
        ok = ok && (a.ssid >= 4'h1) && (a.ssid <= 4'h7);
        for (int k = 0; k < udf_pkg::CALL_CHARS; k++) begin
            c = a.call[8*k +: 8];
            n = (k < 4) ? regs[w][8*k +: 8] : regs[w+1][8*(k-4) +: 8];
            if (k < int'(len)) begin
                ok = ok && (c == n);
            end else if (k == int'(len)) begin
                ok = ok && (c >= udf_pkg::CH_ONE) && (c <= udf_pkg::CH_SEVEN);
            end else begin
                ok = ok && (c == udf_pkg::CH_SPACE);
            end
        end
        nameMatch = ok;
    endfunction

    // insert a field before idx, shifting later fields up
    function automatic udf_pkg::udf_hdr_s insertAt(input udf_pkg::udf_hdr_s h, input logic [2:0] idx,
                                                   input udf_pkg::udf_addr_s a);
        udf_pkg::udf_hdr_s r;
        r = h;
        for (int i = 1; i < udf_pkg::NUM_DIGI; i++) begin
            if (i > int'(idx)) begin
                r.digi[i] = h.digi[i-1];
            end
        end
        r.digi[idx] = a;
        r.numDigi = h.numDigi + 4'h1;
        insertAt = r;
    endfunction

    // decision on the captured frame
    udf_pkg::udf_addr_s own, nxt;
    udf_pkg::udf_hdr_s outHdr;
    logic [3:0] nxtIdx;
    logic found, ownSeen, aliasHit, gateHit, floodHit, traceHit;
    logic special, relayOk, dupHit, roomLeft;
    logic [7:0] hold;
    logic [31:0] cfg;

    always_comb begin
        cfg = regs[udf_pkg::W_CFG];
        own = regAddr(udf_pkg::W_OWN);
        nxtIdx = 4'h0;
        found = 1'b0;
        for (int i = 0; i < udf_pkg::NUM_DIGI; i++) begin
            if (!found && i < int'(frm.numDigi) && !frm.digi[i].rep) begin
                nxtIdx = 4'(i);
                found = 1'b1;
            end
        end
        nxt = frm.digi[nxtIdx[2:0]];
        ownSeen = sameStn(frm.src, own);
        for (int i = 0; i < udf_pkg::NUM_DIGI; i++) begin
            if (i < int'(frm.numDigi) && frm.digi[i].rep && sameStn(frm.digi[i], own)) begin
                ownSeen = 1'b1;
            end
        end
        roomLeft = frm.numDigi < 4'(udf_pkg::NUM_DIGI);
        gateHit = found && sameStn(nxt, regAddr(udf_pkg::W_GATE));
        aliasHit = 1'b0;
        for (int a = 0; a < udf_pkg::NUM_ALIAS; a++) begin
            if (regs[udf_pkg::W_ALIAS + 2*a + 1][udf_pkg::HI_EN]
                && sameStn(nxt, regAddr(udf_pkg::W_ALIAS + 2*a))) begin
                aliasHit = 1'b1;
            end
        end
        aliasHit = aliasHit && found && cfg[udf_pkg::CFG_ALIAS_EN] && !ownSeen;
        floodHit = found && cfg[udf_pkg::CFG_FLOOD_EN] && nameMatch(nxt, udf_pkg::W_FLOOD);
        traceHit = found && cfg[udf_pkg::CFG_TRACE_EN] && !ownSeen
                   && nameMatch(nxt, udf_pkg::W_TRACE);
        outHdr = frm;
        hold = 8'h00;
        special = 1'b0;
        relayOk = 1'b0;
        if (gateHit) begin
            relayOk = cfg[udf_pkg::CFG_GATE0 + int'(frm.port)];
            outHdr.digi[nxtIdx[2:0]].rep = 1'b1;
        end else if (aliasHit) begin
            special = 1'b1;
            hold = cfg[udf_pkg::CFG_DUP_LSB +: 8];
            outHdr.digi[nxtIdx[2:0]] = own;
            outHdr.digi[nxtIdx[2:0]].rep = 1'b1;
        end else if (floodHit) begin
            special = 1'b1;
            hold = regs[udf_pkg::W_FLOOD + 1][udf_pkg::HI_HOLD_LSB +: 8];
            outHdr.digi[nxtIdx[2:0]].ssid = nxt.ssid - 4'h1;
            outHdr.digi[nxtIdx[2:0]].rep = 1'b0;
            if (cfg[udf_pkg::CFG_FLOOD_ID] && roomLeft) begin
                outHdr = insertAt(outHdr, nxtIdx[2:0], '{call: own.call, ssid: own.ssid, rep: 1'b1});
            end
        end else if (traceHit) begin
            special = 1'b1;
            hold = regs[udf_pkg::W_TRACE + 1][udf_pkg::HI_HOLD_LSB +: 8];
            outHdr.digi[nxtIdx[2:0]].ssid = nxt.ssid - 4'h1;
            outHdr.digi[nxtIdx[2:0]].rep = 1'b0;
            if (roomLeft) begin
                outHdr = insertAt(outHdr, nxtIdx[2:0], '{call: own.call, ssid: own.ssid, rep: 1'b1});
            end
        end
        relayOk = (relayOk || special) && frm.isUi;
        dupHit = 1'b0;
        for (int i = 0; i < STORE_DEPTH; i++) begin
            if (stLeft[i] != 8'h00 && stSum[i] == sum) begin
                dupHit = 1'b1;
            end
        end
    end

    // frame sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            udf_pkg::UDF_IDLE: begin
                if (rxHdrValid && rxHdrReady) begin
                    next_state = rxHdr.hasInfo ? udf_pkg::UDF_BODY : udf_pkg::UDF_DECIDE;
                end
            end
            udf_pkg::UDF_BODY: begin
                if (rxDataValid && rxDataReady && rxLast) begin
                    next_state = udf_pkg::UDF_DECIDE;
                end
            end
            udf_pkg::UDF_DECIDE: begin
                next_state = (relayOk && !(special && dupHit)) ? udf_pkg::UDF_OUT : udf_pkg::UDF_IDLE;
            end
            udf_pkg::UDF_OUT: begin
                if (relayReady) begin
                    next_state = udf_pkg::UDF_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= udf_pkg::UDF_IDLE;
            rxHdrReady <= 1'b0;
            rxDataReady <= 1'b0;
        end else begin
            state <= next_state;
            rxHdrReady <= next_state == udf_pkg::UDF_IDLE;
            rxDataReady <= next_state == udf_pkg::UDF_BODY;
        end
    end

    // capture header and accumulate checksum
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frm <= '0;
            sum <= 16'h0000;
        end else if (state == udf_pkg::UDF_IDLE && rxHdrValid && rxHdrReady) begin
            frm <= rxHdr;
            sum <= csAddr(csAddr(16'h0000, rxHdr.src), rxHdr.dest);
        end else if (state == udf_pkg::UDF_BODY && rxDataValid && rxDataReady) begin
            sum <= csStep(sum, rxData);
        end
    end

    // relay output, held until taken
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            relayValid <= 1'b0;
            relay <= '0;
        end else if (state == udf_pkg::UDF_DECIDE) begin
            relayValid <= relayOk && !(special && dupHit);
            relay.hdr <= outHdr;
            relay.outPort <= gateHit ? ~frm.port : frm.port;
            relay.chanWait <= special ? cfg[udf_pkg::CFG_UI_WAIT] : 1'b1;
        end else if (relayValid && relayReady) begin
            relayValid <= 1'b0;
        end
    end

    // duplicate store: age on tick, ring write keeps the oldest at the pointer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            for (int i = 0; i < STORE_DEPTH; i++) begin
                stSum[i] <= 16'h0000;
                stLeft[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < STORE_DEPTH; i++) begin
                if (secTick && stLeft[i] != 8'h00) begin
                    stLeft[i] <= stLeft[i] - 8'h01;
                end
            end
            // zero hold keeps nothing
            if (state == udf_pkg::UDF_DECIDE && relayOk && special && !dupHit && hold != 8'h00) begin
                stSum[wrPtr] <= sum;
                stLeft[wrPtr] <= hold;
                wrPtr <= wrPtr + 1'b1;
            end
        end
    end

    // statistics
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            relayCnt <= 16'h0000;
            dropCnt <= 16'h0000;
        end else if (state == udf_pkg::UDF_DECIDE) begin
            if (relayOk && !(special && dupHit)) begin
                relayCnt <= relayCnt + 16'h0001;
            end else if (special && dupHit) begin
                dropCnt <= dropCnt + 16'h0001;
            end
        end
    end

    // avalon slave: one wait cycle, then answer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                if (int'(avs_address) < udf_pkg::NUM_RW) begin
                    avs_readdata <= regs[avs_address];
                end else if (avs_address == udf_pkg::W_STAT) begin
                    avs_readdata <= {dropCnt, relayCnt};
                end else begin
                    avs_readdata <= 32'h0000_0000;
                end
            end
        end
    end

    // register writes land on the edge with waitrequest low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < udf_pkg::NUM_RW; i++) begin
                regs[i] <= 32'h0000_0000;
            end
            regs[udf_pkg::W_CFG] <= udf_pkg::CFG_RST;
            regs[udf_pkg::W_FLOOD + 1] <= udf_pkg::NAME_HI_RST;
            regs[udf_pkg::W_TRACE + 1] <= udf_pkg::NAME_HI_RST;
            regs[udf_pkg::W_UDEST] <= udf_pkg::UDEST_LO_RST;
            regs[udf_pkg::W_UDEST + 1] <= udf_pkg::UDEST_HI_RST;
        end else if (avs_write && !avs_waitrequest && int'(avs_address) < udf_pkg::NUM_RW) begin
            regs[avs_address] <= avs_writedata;
        end
    end

    // locally originated unconnected frames
    logic [3:0] uCnt;
    logic uNone;
    assign uCnt = regs[udf_pkg::W_UCTL][udf_pkg::UCTL_CNT_LSB +: 4];
    assign uNone = regs[udf_pkg::W_UCTL][udf_pkg::UCTL_NONE];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            localValid <= 1'b0;
            localHdr <= '0;
            localRefused <= 1'b0;
        end else begin
            localRefused <= 1'b0;
            if (localValid) begin
                // single shot: no ack awaited, never resent
                localValid <= !localReady;
            end else if (localReq) begin
                if (uNone && localKind == udf_pkg::UDF_KIND_DATA) begin
                    localRefused <= 1'b1;
                end else begin
                    localValid <= 1'b1;
                    localHdr.dest <= regAddr(udf_pkg::W_UDEST);
                    localHdr.src <= own;
                    for (int i = 0; i < udf_pkg::NUM_DIGI; i++) begin
                        localHdr.digi[i] <= regAddr(udf_pkg::W_UDIGI + 2*i);
                    end
                    // beacon and id with path none go direct
                    localHdr.numDigi <= uNone ? 4'h0 :
                        (uCnt > 4'(udf_pkg::NUM_DIGI) ? 4'(udf_pkg::NUM_DIGI) : uCnt);
                    localHdr.port <= regs[udf_pkg::W_UCTL][udf_pkg::UCTL_PORT];
                    localHdr.isUi <= 1'b1;
                    localHdr.hasInfo <= 1'b1;
                end
            end
        end
    end
endmodule

//--- bench/udf_filter_assertions.sv
`timescale 1ns/1ps
module udf_filter_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rxHdrReady,
    input wire logic rxDataValid,
    input wire logic rxDataReady,
    input wire logic rxLast,
    input wire logic relayValid,
    input wire udf_pkg::udf_relay_s relay,
    input wire logic relayReady,
    input wire logic localValid,
    input wire udf_pkg::udf_hdr_s localHdr,
    input wire logic localReady,
    input wire logic localRefused
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // relay: ui only, bounded path, held until taken
    relay_ui_a: assert property (relayValid |-> relay.hdr.isUi)
        else $error("non-UI relay");
    path_len_a: assert property (relayValid |-> relay.hdr.numDigi <= 4'h8)
        else $error("relay path too long");
    relay_hold_a: assert property (relayValid && !relayReady |=> relayValid && $stable(relay))
        else $error("relay changed before taken");
    // one decide cycle after the last byte; no header meanwhile
    decide_gap_a: assert property (rxDataValid && rxDataReady && rxLast |=> !relayValid)
        else $error("relay too early");
    hdr_block_a: assert property (relayValid |-> !rxHdrReady)
        else $error("header taken while relay pending");
    // local side
    local_ui_a: assert property (localValid |-> localHdr.isUi && localHdr.numDigi <= 4'h8)
        else $error("local frame not UI");
    local_hold_a: assert property (localValid && !localReady |=> localValid && $stable(localHdr))
        else $error("local frame changed");
    refuse_pulse_a: assert property (localRefused |=> !localRefused)
        else $error("refuse longer than one cycle");
    refuse_excl_a: assert property (localRefused |-> !localValid)
        else $error("refused and valid together");
endmodule

bind udf_filter udf_filter_assertions chk (.*);

//--- bench/udf_radio_model.sv
`timescale 1ns/1ps
module udf_radio_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic relayValid,
    input wire logic localValid,
    input wire logic slow,
    output logic relayReady,
    output logic localReady
);
    logic [1:0] stall;
    // relay taken at once, or after a stall when slow
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stall <= 2'h0;
            relayReady <= 1'b0;
        end else begin
            stall <= relayValid ? stall + 2'h1 : 2'h0;
            relayReady <= relayValid && !relayReady && (!slow || stall == 2'h3);
        end
    end
    // one-cycle ready: a held frame is taken once
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            localReady <= 1'b0;
        end else begin
            localReady <= localValid && !localReady;
        end
    end
endmodule

//--- bench/udf_filter_tb_top.sv
`timescale 1ns/1ps
module udf_filter_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic secTick = 1'b0;
    logic rxHdrValid = 1'b0;
    udf_pkg::udf_hdr_s rxHdr = '0;
    logic rxDataValid = 1'b0;
    logic [7:0] rxData = 8'h00;
    logic rxLast = 1'b0;
    logic localReq = 1'b0;
    udf_pkg::udf_kind_e localKind = udf_pkg::UDF_KIND_DATA;
    logic slow = 1'b0;
    logic [31:0] avs_readdata, rdv;
    logic avs_waitrequest, rxHdrReady, rxDataReady, relayValid, relayReady;
    logic localValid, localReady, localRefused, got;
    udf_pkg::udf_relay_s relay, lr;
    udf_pkg::udf_hdr_s localHdr;
    int n_fail = 0;
    int cmp_count = 0;

    udf_filter #(.STORE_DEPTH(4)) dut (.*);
    udf_radio_model radio (.ref_clk(ref_clk), .rst_n(rst_n), .relayValid(relayValid), .localValid(localValid),
        .slow(slow), .relayReady(relayReady), .localReady(localReady));

    // 50 MHz system clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [47:0] cs(input string s);
        logic [47:0] c;
        c = {6{8'h20}};
        for (int k = 0; k < s.len(); k++) c[8*k+:8] = s[k];
        return c;
    endfunction

    task automatic ck(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // avalon access held until waitrequest low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d;
    endtask

    task automatic setCall(input logic [5:0] w, input string s, input logic [15:0] top);
        logic [47:0] c;
        c = cs(s);
        bus(1'b1, w, c[31:0]);
        bus(1'b1, w + 6'h01, {top, c[47:32]});
    endtask

    // header, two info bytes; got flags a relay
    task automatic fr(input string src, input string d0, input logic [3:0] ss, input logic pt, input logic [7:0] b);
        udf_pkg::udf_hdr_s h;
        h = '0;
        h.src.call = cs(src);
        h.dest.call = cs("BEACON");
        h.digi[0].call = cs(d0);
        h.digi[0].ssid = ss;
        h.numDigi = 4'h1;
        h.port = pt;
        h.isUi = 1'b1;
        h.hasInfo = 1'b1;
        @(posedge ref_clk);
        rxHdr <= h;
        rxHdrValid <= 1'b1;
        do @(posedge ref_clk); while (rxHdrReady !== 1'b1);
        rxHdrValid <= 1'b0;
        rxHdr <= ~h;
        for (int i = 0; i < 2; i++) begin
            rxDataValid <= 1'b1;
            rxData <= b + 8'(i);
            rxLast <= (i == 1);
            do @(posedge ref_clk); while (rxDataReady !== 1'b1);
        end
        rxDataValid <= 1'b0;
        rxData <= ~rxData;
        got = 1'b0;
        repeat (8) begin
            @(posedge ref_clk);
            if (relayValid === 1'b1) begin
                got = 1'b1;
                lr = relay;
                break;
            end
        end
        do @(posedge ref_clk); while (rxHdrReady !== 1'b1);
    endtask

    task automatic loc(input udf_pkg::udf_kind_e k);
        repeat (3) @(posedge ref_clk);
        localKind <= k;
        localReq <= 1'b1;
        @(posedge ref_clk);
        localReq <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(1'b0, udf_pkg::W_CFG, 32'h0);
        ck(rdv === udf_pkg::CFG_RST, "cfg reset");
        bus(1'b0, udf_pkg::W_FLOOD + 6'h01, 32'h0);
        ck(rdv === udf_pkg::NAME_HI_RST, "flood hold");
        bus(1'b0, udf_pkg::W_TRACE + 6'h01, 32'h0);
        ck(rdv === udf_pkg::NAME_HI_RST, "trace hold");
        bus(1'b0, 6'h30, 32'h0);
        ck(rdv === 32'h0, "unmapped");
        $display("test regs done");
        setCall(udf_pkg::W_OWN, "OWNCAL", 16'h0000);
        setCall(udf_pkg::W_GATE, "GATEWY", 16'h0000);
        setCall(udf_pkg::W_ALIAS, "RELAYA", 16'h0080);
        setCall(udf_pkg::W_FLOOD, "WIDE", 16'h0540);
        setCall(udf_pkg::W_TRACE, "TRC", 16'h0530);
        bus(1'b1, udf_pkg::W_CFG, 32'h0000_001B);
        // zero hold keeps no checksum, so a repeat goes out again
        repeat (2) fr("SRCA", "RELAYA", 4'h0, 1'b0, 8'h10);
        ck(got === 1'b1, "zero hold");
        ck(lr.hdr.digi[0].call === cs("OWNCAL") && lr.hdr.digi[0].rep === 1'b1, "alias rewrite");
        ck(lr.chanWait === 1'b0 && lr.outPort === 1'b0, "no wait");
        fr("OWNCAL", "RELAYA", 4'h0, 1'b0, 8'h20);
        ck(got === 1'b0, "own source");
        bus(1'b1, udf_pkg::W_CFG, 32'h0000_021B);
        slow <= 1'b1;
        repeat (2) fr("SRCB", "RELAYA", 4'h0, 1'b0, 8'h30);
        ck(got === 1'b0, "duplicate");
        repeat (3) begin
            @(posedge ref_clk) secTick <= 1'b1;
            @(posedge ref_clk) secTick <= 1'b0;
        end
        fr("SRCB", "RELAYA", 4'h0, 1'b0, 8'h30);
        ck(got === 1'b1, "expired");
        // five inserts push the oldest out of four slots
        for (int i = 0; i < 5; i++) fr("SRCC", "RELAYA", 4'h0, 1'b0, 8'h40 + 8'(4 * i));
        fr("SRCC", "RELAYA", 4'h0, 1'b0, 8'h50);
        ck(got === 1'b0, "newest kept");
        fr("SRCC", "RELAYA", 4'h0, 1'b0, 8'h40);
        ck(got === 1'b1, "oldest gone");
        bus(1'b1, udf_pkg::W_CFG, 32'h0000_025B);
        fr("SRCD", "RELAYA", 4'h0, 1'b0, 8'h60);
        ck(got === 1'b1 && lr.chanWait === 1'b1, "slot wait");
        $display("test alias done");
        fr("SRCE", "WIDE3", 4'h2, 1'b0, 8'h70);
        ck(got === 1'b1 && lr.hdr.digi[0].call === cs("WIDE3"), "flood match");
        ck(lr.hdr.digi[0].ssid === 4'h1 && lr.hdr.digi[0].rep === 1'b0, "flood ssid");
        fr("SRCE", "WIDE8", 4'h2, 1'b0, 8'h74);
        ck(got === 1'b0, "bad digit");
        fr("SRCF", "TRC2", 4'h3, 1'b0, 8'h80);
        ck(got === 1'b1 && lr.hdr.numDigi === 4'h2 && lr.hdr.digi[0].rep === 1'b1, "trace insert");
        ck(lr.hdr.digi[1].call === cs("TRC2") && lr.hdr.digi[1].ssid === 4'h2, "trace ssid");
        fr("SRCF", "TRC2", 4'h3, 1'b0, 8'h80);
        ck(got === 1'b0, "trace dup");
        fr("SRCG", "GATEWY", 4'h0, 1'b0, 8'h90);
        ck(got === 1'b1 && lr.outPort === 1'b1, "gate cross");
        fr("SRCG", "GATEWY", 4'h0, 1'b1, 8'h94);
        ck(got === 1'b0, "gate off");
        bus(1'b1, udf_pkg::W_CFG, 32'h0000_005F);
        fr("SRCH", "WIDE2", 4'h2, 1'b0, 8'hA0);
        ck(got === 1'b1 && lr.hdr.numDigi === 4'h2 && lr.hdr.digi[0].call === cs("OWNCAL"), "flood id");
        ck(lr.hdr.digi[0].rep === 1'b1 && lr.hdr.digi[1].ssid === 4'h1, "flood id ssid");
        bus(1'b0, udf_pkg::W_STAT, 32'h0);
        ck(rdv === 32'h0003_000F, "status counts");
        $display("test flood done");
        setCall(udf_pkg::W_UDIGI, "HOPA", 16'h0003);
        bus(1'b1, udf_pkg::W_UCTL, 32'h0000_0001);
        loc(udf_pkg::UDF_KIND_DATA);
        ck(localValid === 1'b1 && localHdr.dest.call === cs("CQ") && localHdr.isUi === 1'b1, "local");
        ck(localHdr.numDigi === 4'h1 && localHdr.digi[0].ssid === 4'h3, "path");
        bus(1'b1, udf_pkg::W_UCTL, 32'h0000_0010);
        loc(udf_pkg::UDF_KIND_DATA);
        ck(localRefused === 1'b1, "none refuses");
        loc(udf_pkg::UDF_KIND_BEACON);
        ck(localValid === 1'b1, "beacon");
        loc(udf_pkg::UDF_KIND_ID);
        ck(localValid === 1'b1, "ident");
        $display("test local done");
        tally_and_finish();
    end

    // far beyond the few hundred cycles needed
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        $display("CHECK FAILED %0t watchdog", $time);
        tally_and_finish();
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
endmodule
